/* pkg/scc_pkg.sv */
// Purpose: Shared constants for the secondary core enable and reset coupling block.
// Assumes: 16-bit control and status words as seen by the primary core.
// Notes: Bit positions, key values and reset values are named here; some files also repeat them as literals.
package scc_pkg;

    localparam int SCC_WORD_W = 16;
    localparam int SCC_KEY_W = 8;
    localparam int SCC_PTR_W = 7;

    // Control word field positions.
    localparam int SCC_CTL_RUN_BIT = 15;
    localparam int SCC_CTL_P2S_REQ_BIT = 9;
    localparam int SCC_CTL_S2P_ACK_BIT = 8;
    localparam int SCC_CTL_RST_IE_BIT = 7;
    localparam int SCC_PTR_LSB = 0;

    // Status word field positions.
    localparam int SCC_STAT_IN_RST_BIT = 15;
    localparam int SCC_STAT_S2P_REQ_BIT = 9;
    localparam int SCC_STAT_P2S_ACK_BIT = 8;

    // Unlock key values, first and second, and the value the key port reads back.
    localparam logic [SCC_KEY_W-1:0] SCC_KEY_FIRST = 8'h55;
    localparam logic [SCC_KEY_W-1:0] SCC_KEY_SECOND = 8'hAA;
    localparam logic [SCC_KEY_W-1:0] SCC_KEY_READ_VALUE = 8'h00;

    // Reset values.
    localparam logic SCC_RUN_RESET = 1'b0;
    localparam logic SCC_IN_RST_RESET = 1'b1;
    localparam logic [SCC_PTR_W-1:0] SCC_PTR_RESET = 7'h00;
    localparam logic [SCC_WORD_W-1:0] SCC_WORD_ZERO = 16'h0000;

    // Index of each pin input in the synchroniser vector.
    localparam int SCC_SYN_SEC_RST = 0;
    localparam int SCC_SYN_CLR_RST = 1;
    localparam int SCC_SYN_PRI_RST = 2;
    localparam int SCC_SYN_FUSE_CPL = 3;
    localparam int SCC_SYN_FUSE_SELF = 4;
    localparam int SCC_SYN_S2P_REQ = 5;
    localparam int SCC_SYN_P2S_ACK = 6;
    localparam int SCC_SYN_N = 7;

    // Unlock sequencer states.
    typedef enum logic [1:0] {
        SCC_KEY_IDLE,
        SCC_KEY_HALF,
        SCC_KEY_OPEN
    } scc_key_state_e;

endpackage

/* pkg/scc_unlock_if.sv */
// Purpose: Carries the unlock window between the sequencer and the core controller.
// Assumes: Both ends run on the same clock.
// Notes: The sequencer owns the window; the controller only reports consumption.
`timescale 1ns/1ps
interface scc_unlock_if;
    logic window_open;
    logic window_used;

    modport seq (output window_open, input window_used);
    modport core (input window_open, output window_used);
endinterface

/* hdl/scc_key_unlock.sv */
// Purpose: Two-write key sequencer that opens a one-instruction write window.
// Assumes: key_wr and instr_step are single-cycle pulses from the primary core.
// Notes: Private state, never shared with any other unlock logic.
`timescale 1ns/1ps
module scc_key_unlock
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic key_wr,
    input wire logic [SCC_KEY_W-1:0] key_wdata,
    input wire logic instr_step,
    scc_unlock_if.seq unl
);

    scc_key_state_e state_ff;
    scc_key_state_e nxt_state;

    // Next state: wrong order restarts, window lasts one instruction.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCC_KEY_IDLE: begin
                if (key_wr && key_wdata == SCC_KEY_FIRST) begin
                    nxt_state = SCC_KEY_HALF;
                end
            end
            SCC_KEY_HALF: begin
                if (key_wr) begin
                    if (key_wdata == SCC_KEY_SECOND) begin
                        nxt_state = SCC_KEY_OPEN;
                    end else if (key_wdata == SCC_KEY_FIRST) begin
                        nxt_state = SCC_KEY_HALF;
                    end else begin
                        nxt_state = SCC_KEY_IDLE;
                    end
                end else if (instr_step || unl.window_used) begin
                    nxt_state = SCC_KEY_IDLE;
                end
            end
            SCC_KEY_OPEN: begin
                if (key_wr && key_wdata == SCC_KEY_FIRST) begin
                    nxt_state = SCC_KEY_HALF;
                end else if (key_wr || instr_step || unl.window_used) begin
                    nxt_state = SCC_KEY_IDLE;
                end
            end
            default: begin
                nxt_state = SCC_KEY_IDLE;
            end
        endcase
    end

    // State register, kept apart from any other unlock mechanism.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= SCC_KEY_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // The window is open only in the state after the second key.
    assign unl.window_open = (state_ff == SCC_KEY_OPEN);

endmodule

/* hdl/scc_core_ctrl.sv */
// Purpose: Primary-side control of the secondary core: enable, reset coupling, handshakes.
// Assumes: Register writes arrive as one-cycle strobes from the primary core on clk.
// Notes: Pins from the secondary domain and the reset sources pass a 3-stage filter.
`timescale 1ns/1ps
// Notes on behaviour
// - Run enable low holds secondary in reset.
// - Disabled secondary gives primary code RAM access.
// - In-reset flag is 1 unless running.
// - Enabling releases reset, removes RAM access.
// - Reset interrupt only on entering reset.
// - Keys 0x55 then 0xAA open window.
// - Unlock guards run bit only, both ways.
// - Key port has no storage, reads zero.
// - Unlock state separate from flash unlock.
// - Self fuse 0: only power and external clear resets disable.
// - Fuses 0/1: secondary resets disable only.
// - Fuses 1/1: any reset disables secondary.
// - Restart without disable still raises interrupt.
// - Request bits at bit 9 each way.
// - Acknowledge bits at bit 8 each way.
// - Acknowledge without request is protocol error.
// - FIFO pointers accessible only in debug.
module scc_core_ctrl
    import scc_pkg::*;
#(
    parameter int PTR_W = SCC_PTR_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_wr,
    input wire logic [SCC_WORD_W-1:0] ctl_wdata,
    output logic [SCC_WORD_W-1:0] ctl_rdata,
    output logic [SCC_WORD_W-1:0] stat_rdata,
    input wire logic key_wr,
    input wire logic [SCC_KEY_W-1:0] key_wdata,
    output logic [SCC_KEY_W-1:0] key_rdata,
    input wire logic instr_step,
    input wire logic debug_mode,
    input wire logic [PTR_W-1:0] write_fifo_pointer_in,
    input wire logic sec_runtime_rst,
    input wire logic external_clear_reset,
    input wire logic pri_runtime_rst,
    input wire logic primary_reset_coupling_fuse,
    input wire logic secondary_self_reset_fuse,
    input wire logic secondary_to_primary_irq_request,
    input wire logic primary_to_secondary_irq_ack,
    output logic secondary_hold_reset,
    output logic secondary_code_ram_primary_access,
    output logic secondary_reset_irq,
    output logic primary_to_secondary_irq_request,
    output logic secondary_to_primary_irq_ack,
    output logic ack_protocol_error,
    output logic [PTR_W-1:0] read_fifo_pointer
);

    logic [SCC_SYN_N-1:0] pins_in;
    logic [SCC_SYN_N-1:0] syn1_ff;
    logic [SCC_SYN_N-1:0] syn2_ff;
    logic [SCC_SYN_N-1:0] syn3_ff;
    logic [SCC_SYN_N-1:0] pin_ff;
    logic sec_rst;
    logic clr_rst;
    logic pri_rst;
    logic fuse_cpl;
    logic fuse_self;
    logic s2p_req;
    logic p2s_ack;
    logic p2s_ack_prev_ff;
    logic secondary_run_enable_ff;
    logic nxt_secondary_run_enable;
    logic rst_ie_ff;
    logic p2s_req_ff;
    logic s2p_ack_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic in_reset;
    logic in_reset_prev_ff;
    logic irq_ff;
    logic err_ff;
    logic run_write;
    logic run_clear;
    logic bad_ack_write;
    logic bad_ack_seen;

    scc_unlock_if unl ();

    // Key sequencer in its own module so its state is never shared.
    scc_key_unlock u_key (
        .clk(clk),
        .rst_n(rst_n),
        .key_wr(key_wr),
        .key_wdata(key_wdata),
        .instr_step(instr_step),
        .unl(unl)
    );

    // Key port holds nothing and always reads as zero.
    assign key_rdata = SCC_KEY_READ_VALUE;

    // Gather the pins that come from outside this clock domain.
    assign pins_in[SCC_SYN_SEC_RST] = sec_runtime_rst;
    assign pins_in[SCC_SYN_CLR_RST] = external_clear_reset;
    assign pins_in[SCC_SYN_PRI_RST] = pri_runtime_rst;
    assign pins_in[SCC_SYN_FUSE_CPL] = primary_reset_coupling_fuse;
    assign pins_in[SCC_SYN_FUSE_SELF] = secondary_self_reset_fuse;
    assign pins_in[SCC_SYN_S2P_REQ] = secondary_to_primary_irq_request;
    assign pins_in[SCC_SYN_P2S_ACK] = primary_to_secondary_irq_ack;

    // Three stages per pin; a change is taken once stages two and three agree.
    for (genvar i = 0; i < SCC_SYN_N; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                syn1_ff[i] <= 1'b0;
                syn2_ff[i] <= 1'b0;
                syn3_ff[i] <= 1'b0;
                pin_ff[i] <= 1'b0;
            end else begin
                syn1_ff[i] <= pins_in[i];
                syn2_ff[i] <= syn1_ff[i];
                syn3_ff[i] <= syn2_ff[i];
                if (syn2_ff[i] == syn3_ff[i]) begin
                    pin_ff[i] <= syn3_ff[i];
                end
            end
        end
    end

    assign sec_rst = pin_ff[SCC_SYN_SEC_RST];
    assign clr_rst = pin_ff[SCC_SYN_CLR_RST];
    assign pri_rst = pin_ff[SCC_SYN_PRI_RST];
    assign fuse_cpl = pin_ff[SCC_SYN_FUSE_CPL];
    assign fuse_self = pin_ff[SCC_SYN_FUSE_SELF];
    assign s2p_req = pin_ff[SCC_SYN_S2P_REQ];
    assign p2s_ack = pin_ff[SCC_SYN_P2S_ACK];

    // Run bit write is honoured only inside the open key window.
    assign run_write = ctl_wr && unl.window_open;
    assign unl.window_used = ctl_wr;

    // Reset coupling selected by the two fuses.
    always_comb begin
        run_clear = clr_rst;
        if (fuse_self && sec_rst) begin
            run_clear = 1'b1;
        end
        if (fuse_self && fuse_cpl && pri_rst) begin
            run_clear = 1'b1;
        end
    end

    // Next run enable: coupled resets win over a software set.
    always_comb begin
        nxt_secondary_run_enable = secondary_run_enable_ff;
        if (run_write) begin
            nxt_secondary_run_enable = ctl_wdata[SCC_CTL_RUN_BIT];
        end
        if (run_clear) begin
            nxt_secondary_run_enable = 1'b0;
        end
    end

    // Run enable register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            secondary_run_enable_ff <= SCC_RUN_RESET;
        end else begin
            secondary_run_enable_ff <= nxt_secondary_run_enable;
        end
    end

    // Free control bits: written without any unlock.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_ie_ff <= 1'b0;
            p2s_req_ff <= 1'b0;
        end else if (ctl_wr) begin
            rst_ie_ff <= ctl_wdata[SCC_CTL_RST_IE_BIT];
            p2s_req_ff <= ctl_wdata[SCC_CTL_P2S_REQ_BIT];
        end
    end

    // Acknowledge to the secondary request; refused when no request stands.
    assign bad_ack_write = ctl_wr && ctl_wdata[SCC_CTL_S2P_ACK_BIT] && !s2p_req;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s2p_ack_ff <= 1'b0;
        end else if (ctl_wr) begin
            s2p_ack_ff <= ctl_wdata[SCC_CTL_S2P_ACK_BIT] && s2p_req;
        end
    end

    // Read pointer changes only from debug mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr_ff <= SCC_PTR_RESET;
        end else if (ctl_wr && debug_mode) begin
            rd_ptr_ff <= ctl_wdata[SCC_PTR_LSB +: PTR_W];
        end
    end

    // Acknowledge rising from the secondary while no request was made.
    assign bad_ack_seen = p2s_ack && !p2s_ack_prev_ff && !p2s_req_ff;

    // Registered protocol error pulse for either direction.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2s_ack_prev_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            p2s_ack_prev_ff <= p2s_ack;
            err_ff <= bad_ack_write || bad_ack_seen;
        end
    end

    // Secondary is in reset while disabled or while its own reset runs.
    assign in_reset = !secondary_run_enable_ff || sec_rst;

    // Interrupt on entry into reset; prior state starts as in-reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_reset_prev_ff <= SCC_IN_RST_RESET;
            irq_ff <= 1'b0;
        end else begin
            in_reset_prev_ff <= in_reset;
            irq_ff <= in_reset && !in_reset_prev_ff && rst_ie_ff;
        end
    end

    // Reset hold follows the in-reset flag; code RAM access follows the run state.
    assign secondary_hold_reset = in_reset;
    assign secondary_code_ram_primary_access = !secondary_run_enable_ff;
    assign secondary_reset_irq = irq_ff;
    assign primary_to_secondary_irq_request = p2s_req_ff;
    assign secondary_to_primary_irq_ack = s2p_ack_ff;
    assign ack_protocol_error = err_ff;
    assign read_fifo_pointer = rd_ptr_ff;

    // Control read-back; pointer field shows only in debug mode.
    always_comb begin
        ctl_rdata = SCC_WORD_ZERO;
        ctl_rdata[SCC_CTL_RUN_BIT] = secondary_run_enable_ff;
        ctl_rdata[SCC_CTL_P2S_REQ_BIT] = p2s_req_ff;
        ctl_rdata[SCC_CTL_S2P_ACK_BIT] = s2p_ack_ff;
        ctl_rdata[SCC_CTL_RST_IE_BIT] = rst_ie_ff;
        if (debug_mode) begin
            ctl_rdata[SCC_PTR_LSB +: PTR_W] = rd_ptr_ff;
        end
    end

    // Status read-back.
    always_comb begin
        stat_rdata = SCC_WORD_ZERO;
        stat_rdata[SCC_STAT_IN_RST_BIT] = in_reset;
        stat_rdata[SCC_STAT_S2P_REQ_BIT] = s2p_req;
        stat_rdata[SCC_STAT_P2S_ACK_BIT] = p2s_ack;
        if (debug_mode) begin
            stat_rdata[SCC_PTR_LSB +: PTR_W] = write_fifo_pointer_in;
        end
    end

endmodule

/* sim/scc_ctrl_sva.sv */
// Purpose: Port checker for the secondary core control block.
// Assumes: Reset pins stay low for seven cycles before an unlocked write.
// Notes: Bound to every scc_core_ctrl instance.
`timescale 1ns/1ps
module scc_ctrl_sva
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_wr,
    input wire logic [SCC_WORD_W-1:0] ctl_wdata,
    input wire logic [SCC_WORD_W-1:0] ctl_rdata,
    input wire logic [SCC_WORD_W-1:0] stat_rdata,
    input wire logic key_wr,
    input wire logic [SCC_KEY_W-1:0] key_wdata,
    input wire logic [SCC_KEY_W-1:0] key_rdata,
    input wire logic debug_mode,
    input wire logic instr_step,
    input wire logic sec_runtime_rst,
    input wire logic external_clear_reset,
    input wire logic pri_runtime_rst,
    input wire logic secondary_hold_reset,
    input wire logic secondary_code_ram_primary_access,
    input wire logic secondary_reset_irq,
    input wire logic primary_to_secondary_irq_request,
    input wire logic secondary_to_primary_irq_ack,
    input wire logic ack_protocol_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] quiet_ff;
    // Counts cycles with all reset pins low, so filtered resets have drained.
    always_ff @(posedge clk) begin
        if (!rst_n || sec_runtime_rst || external_clear_reset || pri_runtime_rst) begin
            quiet_ff <= 3'h0;
        end else if (quiet_ff != 3'h7) begin
            quiet_ff <= quiet_ff + 3'h1;
        end
    end
    // A cycle with no instruction, key write or control write in it.
    sequence gap_s;
        !key_wr && !ctl_wr && !instr_step;
    endsequence
    // The two key writes in order, with one quiet cycle between.
    sequence key_pair_s;
        key_wr && key_wdata == SCC_KEY_FIRST ##1 gap_s ##1 key_wr && key_wdata == SCC_KEY_SECOND;
    endsequence
    sequence run_write_s;
        ctl_wr && ctl_wdata[SCC_CTL_RUN_BIT] && quiet_ff == 3'h7;
    endsequence
    unlock_set_a: assert property (key_pair_s ##1 gap_s ##1 run_write_s |=> ctl_rdata[15])
        else $error("unlocked run write was not taken");
    run_locked_a: assert property ((ctl_wr && quiet_ff == 3'h7 && !$past(key_wr)
        && !$past(key_wr, 2)) |=> $stable(ctl_rdata[15]))
        else $error("run bit changed without unlock");
    held_off_a: assert property (!ctl_rdata[15] |-> secondary_hold_reset
        && secondary_code_ram_primary_access && stat_rdata[15])
        else $error("disabled secondary not held with ram access");
    running_a: assert property (ctl_rdata[15] && quiet_ff == 3'h7 |-> !secondary_hold_reset
        && !secondary_code_ram_primary_access && !stat_rdata[15])
        else $error("enabled secondary not released");
    irq_edge_a: assert property (secondary_reset_irq |-> $past(stat_rdata[15])
        && !$past(stat_rdata[15], 2) ##1 !secondary_reset_irq)
        else $error("reset interrupt without entry into reset");
    key_zero_a: assert property (key_rdata == SCC_KEY_READ_VALUE)
        else $error("key port read not zero");
    req_write_a: assert property (ctl_wr |=>
        primary_to_secondary_irq_request == $past(ctl_wdata[SCC_CTL_P2S_REQ_BIT]))
        else $error("request bit not written");
    ack_err_a: assert property (ctl_wr && ctl_wdata[8] && !stat_rdata[9]
        |=> ack_protocol_error && !secondary_to_primary_irq_ack)
        else $error("stray acknowledge not refused");
    ack_ok_a: assert property (ctl_wr && ctl_wdata[8] && stat_rdata[9]
        |=> secondary_to_primary_irq_ack && !ack_protocol_error)
        else $error("valid acknowledge not stored");
    ptr_hidden_a: assert property (!debug_mode |-> ctl_rdata[6:0] == 7'h00
        && stat_rdata[6:0] == 7'h00)
        else $error("pointer visible outside debug");
    clear_rst_a: assert property (external_clear_reset [*8] |-> !ctl_rdata[15])
        else $error("clear reset left secondary enabled");
endmodule
bind scc_core_ctrl scc_ctrl_sva scc_ctrl_sva_i (
    .clk(clk),
    .rst_n(rst_n),
    .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata),
    .stat_rdata(stat_rdata),
    .key_wr(key_wr),
    .key_wdata(key_wdata),
    .key_rdata(key_rdata),
    .debug_mode(debug_mode),
    .instr_step(instr_step),
    .sec_runtime_rst(sec_runtime_rst),
    .external_clear_reset(external_clear_reset),
    .pri_runtime_rst(pri_runtime_rst),
    .secondary_hold_reset(secondary_hold_reset),
    .secondary_code_ram_primary_access(secondary_code_ram_primary_access),
    .secondary_reset_irq(secondary_reset_irq),
    .primary_to_secondary_irq_request(primary_to_secondary_irq_request),
    .secondary_to_primary_irq_ack(secondary_to_primary_irq_ack),
    .ack_protocol_error(ack_protocol_error)
);

/* sim/scc_sec_model.sv */
// Purpose: Behavioural secondary core: answers requests and raises resets.
// Assumes: Same clock as the primary side.
// Notes: Acknowledges with no request only when told to, to provoke a protocol error.
`timescale 1ns/1ps
module scc_sec_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic p2s_req,
    input wire logic raise_req,
    input wire logic crash,
    input wire logic stray,
    output logic s2p_req_ff,
    output logic p2s_ack_ff,
    output logic sec_rst_ff
);
    logic seen_ff;
    // Acknowledges a request one cycle after seeing it and drops with it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_ff <= 1'b0;
            p2s_ack_ff <= 1'b0;
            s2p_req_ff <= 1'b0;
            sec_rst_ff <= 1'b0;
        end else begin
            seen_ff <= p2s_req;
            p2s_ack_ff <= (p2s_req && seen_ff) || stray;
            s2p_req_ff <= raise_req;
            sec_rst_ff <= crash;
        end
    end
endmodule

/* sim/testbench.sv */
// Purpose: Directed test of unlock, reset coupling, handshakes and debug pointers.
// Assumes: Partner model stands for the secondary core.
// Notes: Strobes are one-cycle pulses with an idle cycle between.
`timescale 1ns/1ps
module testbench;
    import scc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ctl_wr = 1'b0, key_wr = 1'b0, instr_step = 1'b0;
    logic debug_mode = 1'b0, cpl = 1'b1, slf = 1'b1, pri = 1'b0, clr = 1'b0;
    logic raise_req = 1'b0, crash = 1'b0, sec, s2p, p2s_ack, hold, ram, irq, p2s, s2p_ack, perr;
    logic stray = 1'b0;
    logic [15:0] ctl_wdata = 16'h0000, ctl_rdata, stat_rdata;
    logic [7:0] key_wdata = 8'h00, key_rdata;
    logic [6:0] wptr = 7'h33, rptr;
    logic exp_run;
    int error_cnt = 0, tests_run = 0, irq_cnt = 0, perr_cnt = 0, n0;
    scc_core_ctrl scc_core_ctrl_i (.clk, .rst_n, .ctl_wr, .ctl_wdata, .ctl_rdata, .stat_rdata,
        .key_wr, .key_wdata, .key_rdata, .instr_step, .debug_mode, .write_fifo_pointer_in(wptr),
        .sec_runtime_rst(sec), .external_clear_reset(clr), .pri_runtime_rst(pri),
        .primary_reset_coupling_fuse(cpl), .secondary_self_reset_fuse(slf),
        .secondary_to_primary_irq_request(s2p), .primary_to_secondary_irq_ack(p2s_ack),
        .secondary_hold_reset(hold), .secondary_code_ram_primary_access(ram),
        .secondary_reset_irq(irq), .primary_to_secondary_irq_request(p2s),
        .secondary_to_primary_irq_ack(s2p_ack), .ack_protocol_error(perr),
        .read_fifo_pointer(rptr));
    scc_sec_model scc_sec_model_i (.clk, .rst_n, .p2s_req(p2s), .raise_req, .crash,
        .stray, .s2p_req_ff(s2p), .p2s_ack_ff(p2s_ack), .sec_rst_ff(sec));
    // Clock of 20 ns period.
    always #10 clk = ~clk;
    // Counts the one-cycle interrupt and error pulses.
    always @(posedge clk) begin
        if (irq === 1'b1) irq_cnt++;
        if (perr === 1'b1) perr_cnt++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ctl(input logic [15:0] d);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_wdata <= d;
        @(posedge clk);
        ctl_wr <= 1'b0;
    endtask
    task automatic key(input logic [7:0] k);
        @(posedge clk);
        key_wr <= 1'b1;
        key_wdata <= k;
        @(posedge clk);
        key_wr <= 1'b0;
    endtask
    task automatic step;
        @(posedge clk);
        instr_step <= 1'b1;
        @(posedge clk);
        instr_step <= 1'b0;
    endtask
    task automatic unlock(input logic [15:0] d);
        key(SCC_KEY_FIRST);
        key(SCC_KEY_SECOND);
        ctl(d);
        idle(2);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
    // Main sequence of directed scenarios.
    initial begin
        idle(6);
        rst_n <= 1'b1;
        idle(2);
        chk(16'({hold, ram, stat_rdata[15], ctl_rdata[15]}), 16'hE);
        chk(16'(key_rdata), 16'h0000);
        ctl(16'h8080);
        key(SCC_KEY_SECOND);
        key(SCC_KEY_FIRST);
        ctl(16'h8080);
        key(SCC_KEY_FIRST);
        step();
        key(SCC_KEY_SECOND);
        ctl(16'h8080);
        unlock(16'h0080);
        step();
        ctl(16'h8080);
        idle(2);
        chk(ctl_rdata, 16'h0080);
        chk(16'(irq_cnt), 16'h0000);
        unlock(16'h8080);
        chk(16'({ctl_rdata[15], hold, ram, stat_rdata[15]}), 16'h8);
        ctl(16'h0280);
        n0 = 0;
        while (stat_rdata[8] !== 1'b1 && n0 < 20) begin
            idle(1);
            n0++;
        end
        chk(16'({ctl_rdata[15], stat_rdata[8]}), 16'h3);
        if (n0 == 20) complete_run();
        ctl(16'h0180);
        raise_req <= 1'b1;
        idle(6);
        ctl(16'h0180);
        idle(2);
        chk(16'({s2p_ack, stat_rdata[9]}), 16'h3);
        chk(16'(perr_cnt), 16'h1);
        // An acknowledge from the secondary with no request standing.
        stray <= 1'b1;
        idle(2);
        stray <= 1'b0;
        idle(8);
        chk(16'(perr_cnt), 16'h2);
        debug_mode <= 1'b1;
        ctl(16'h00DA);
        idle(2);
        chk(16'({rptr, stat_rdata[6:0]}), 16'h2D33);
        debug_mode <= 1'b0;
        ctl(16'h00A5);
        idle(2);
        chk(16'({rptr, ctl_rdata[6:0]}), 16'h2D00);
        // Each fuse setting against each reset source.
        for (int f = 0; f < 4; f++) begin
            for (int s = 0; s < 3; s++) begin
                cpl <= f[1];
                slf <= f[0];
                unlock(16'h8080);
                idle(6);
                n0 = irq_cnt;
                crash <= (s == 0);
                pri <= (s == 1);
                clr <= (s == 2);
                idle(10);
                crash <= 1'b0;
                pri <= 1'b0;
                clr <= 1'b0;
                idle(10);
                exp_run = !(s == 2 || (s == 0 && f[0]) || (s == 1 && f == 3));
                chk(16'(ctl_rdata[15]), 16'(exp_run));
                if (s == 0 || exp_run) chk(16'(irq_cnt - n0), 16'(s == 0));
            end
        end
        // A power-on reset in mid-run disables the secondary without an interrupt.
        unlock(16'h8080);
        n0 = irq_cnt;
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(2);
        chk(16'({ctl_rdata[15], hold, ram, stat_rdata[15]}), 16'h7);
        chk(16'(irq_cnt - n0), 16'h0000);
        complete_run();
    end
endmodule
